/* src/csc_consts.svh */
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

// register byte offsets (one aligned word each)
`define CSC_ADDR_CTRL 8'h00
`define CSC_ADDR_CFG 8'h04
`define CSC_ADDR_STAT 8'h08
`define CSC_ADDR_FAIL 8'h0c

// control register fields
`define CSC_CTRL_IFO_EN 0
`define CSC_CTRL_EFO_EN 1
`define CSC_CTRL_PLL_EN 2
`define CSC_CTRL_ISO_EN 3
`define CSC_CTRL_ESO_EN 4
`define CSC_CTRL_MON_EN 5
`define CSC_CTRL_EFO_BYP 6
`define CSC_CTRL_ESO_BYP 7

// configuration register fields
`define CSC_CFG_SEL_LO 0
`define CSC_CFG_PLL_SRC 2
`define CSC_CFG_CAL_LO 3

// status register fields
`define CSC_STAT_IFO_RDY 0
`define CSC_STAT_EFO_RDY 1
`define CSC_STAT_PLL_RDY 2
`define CSC_STAT_ISO_RDY 3
`define CSC_STAT_ESO_RDY 4
`define CSC_STAT_SEL_LO 5
`define CSC_STAT_MON_ARM 7

// reset values: internal fast and internal slow run, fast internal selected
`define CSC_CTRL_RST 8'h09
`define CSC_CFG_RST 8'h00

// timing: startup delay of the external fast oscillator, 2 ms at 5 ns
`define CSC_CLK_PERIOD_NS 5
`define CSC_EFO_START_US 2000
`define CSC_EFO_START_CYC ((`CSC_EFO_START_US * 1000) / `CSC_CLK_PERIOD_NS)
// the external clock is declared dead after this many core cycles without an edge
`define CSC_MISS_CYC 16'h00c8
// glitch-free switch: cycles the old source is held off before the new takes over
`define CSC_SW_GAP 4'h3

`endif

/* src/csc_pkg.sv */
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_SRC_IFO = 2'b00,
    CSC_SRC_EFO = 2'b01,
    CSC_SRC_PLL = 2'b10
  } csc_src_e;

  typedef enum logic [1:0] {
    CSC_CAL_NONE = 2'b00,
    CSC_CAL_ESO = 2'b01,
    CSC_CAL_ISO = 2'b10
  } csc_cal_e;

  typedef enum logic [1:0] {
    CSC_MON_OFF = 2'b00,
    CSC_MON_WAIT = 2'b01,
    CSC_MON_RUN = 2'b10
  } csc_mon_e;
endpackage : csc_pkg

/* src/csc_mon_if.sv */
`timescale 1ns/10ps
interface csc_mon_if;
  logic mon_en;
  logic efo_en;
  logic efo_edge;
  logic armed;
  logic fail;

  modport ctrl (output mon_en, output efo_en, output efo_edge, input armed, input fail);
  modport mon (input mon_en, input efo_en, input efo_edge, output armed, output fail);
endinterface : csc_mon_if

/* src/csc_clock_monitor.sv */
`timescale 1ns/10ps
`include "csc_consts.svh"

module csc_clock_monitor #(
  parameter int START_CYC = `CSC_EFO_START_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to the controller
  csc_mon_if.mon mif
);
  localparam logic [19:0] START_LAST = 20'(START_CYC - 1);

  csc_pkg::csc_mon_e state_r;
  logic [19:0] wait_r;
  logic [15:0] miss_r;
  logic fail_r;

  assign mif.armed = (state_r == csc_pkg::CSC_MON_RUN);
  assign mif.fail = fail_r;

  // ----------------------------------------------------------------
  // arming sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= csc_pkg::CSC_MON_OFF;
      wait_r <= 20'h00000;
    end else if (!mif.mon_en || !mif.efo_en || fail_r) begin
      state_r <= csc_pkg::CSC_MON_OFF;
      wait_r <= 20'h00000;
    end else begin
      case (state_r)
        csc_pkg::CSC_MON_OFF: begin
          state_r <= csc_pkg::CSC_MON_WAIT;
          wait_r <= 20'h00000;
        end
        csc_pkg::CSC_MON_WAIT: begin
          // checking starts only once the oscillator has had time to start
          if (wait_r == START_LAST) begin
            state_r <= csc_pkg::CSC_MON_RUN;
          end else begin
            wait_r <= wait_r + 20'h00001;
          end
        end
        csc_pkg::CSC_MON_RUN: state_r <= csc_pkg::CSC_MON_RUN;
        default: state_r <= csc_pkg::CSC_MON_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // missing-edge detector
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miss_r <= 16'h0000;
      fail_r <= 1'b0;
    end else if (state_r != csc_pkg::CSC_MON_RUN || mif.efo_edge) begin
      miss_r <= 16'h0000;
      fail_r <= 1'b0;
    end else if (miss_r == `CSC_MISS_CYC) begin
      fail_r <= 1'b1;
      miss_r <= 16'h0000;
    end else begin
      miss_r <= miss_r + 16'h0001;
      fail_r <= 1'b0;
    end
  end
endmodule : csc_clock_monitor

/* src/csc_clock_source_security_ctrl.sv */
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`include "csc_consts.svh"

// Overview of operation
// - The core clock comes from exactly one of internal fast, external fast or PLL.
// - The 32 kHz internal slow clock always feeds the watchdog and may feed the calendar.
// - The 32.768 kHz external slow clock may be chosen as the calendar clock.
// - Each oscillator and the PLL has its own enable, except internal slow, which runs regardless of its enable bit.
// - The clock monitor is off after reset and runs only when software enables it.
// - After enable the monitor checks only once the external fast startup delay is over.
// - The monitor is disabled whenever the external fast oscillator is stopped.
// - On a detected failure hardware clears the external fast oscillator enable.
// - On a detected failure a clock failure event goes to the timer break input.
// - On a detected failure the clock failure interrupt is raised.
// - The clock failure interrupt goes to the non-maskable interrupt line only.
// - If the core clock derives from external fast at failure, it moves to internal fast.
// - If external fast feeds the PLL driving the core clock at failure, the PLL is disabled.
module csc_clock_source_security_ctrl #(
  parameter int START_CYC = `CSC_EFO_START_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // oscillator enables and ready pins
  output logic ifo_en_o,
  output logic efo_en_o,
  output logic efo_bypass_o,
  output logic pll_en_o,
  output logic iso_en_o,
  output logic eso_en_o,
  output logic eso_bypass_o,
  input wire logic ifo_rdy_i,
  input wire logic efo_rdy_i,
  input wire logic pll_rdy_i,
  input wire logic iso_rdy_i,
  input wire logic eso_rdy_i,
  // external fast clock sampled for the monitor
  input wire logic efo_clk_i,
  // clock steering
  output logic [1:0] core_sel_o,
  output logic core_gate_o,
  output logic pll_src_efo_o,
  output logic [1:0] cal_sel_o,
  output logic wdog_clk_en_o,
  // failure outputs
  output logic tim_break_o,
  output logic nmi_o
);
  logic [7:0] ctrl_r;
  logic [7:0] cfg_r;
  logic fail_flag_r;
  logic [1:0] cur_sel_r;
  logic [3:0] gap_r;
  logic [4:0] rdy_s1_r;
  logic [4:0] rdy_s2_r;
  logic [2:0] eclk_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic brk_r;
  logic nmi_r;
  logic gate_r;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_fail;
  logic fail_ev;
  logic [1:0] want_sel;
  csc_mon_if mif ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  function automatic logic src_ok(input logic [1:0] s, input logic [7:0] c);
    case (s)
      csc_pkg::CSC_SRC_IFO: src_ok = c[`CSC_CTRL_IFO_EN];
      csc_pkg::CSC_SRC_EFO: src_ok = c[`CSC_CTRL_EFO_EN];
      csc_pkg::CSC_SRC_PLL: src_ok = c[`CSC_CTRL_PLL_EN];
      default: src_ok = 1'b0;
    endcase
  endfunction : src_ok

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, `CSC_ADDR_CTRL);
  assign wr_cfg = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, `CSC_ADDR_CFG);
  assign wr_fail = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, `CSC_ADDR_FAIL);
  assign fail_ev = mif.fail;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_s1_r <= 5'h00;
      rdy_s2_r <= 5'h00;
      eclk_r <= 3'h0;
    end else begin
      rdy_s1_r <= {eso_rdy_i, iso_rdy_i, pll_rdy_i, efo_rdy_i, ifo_rdy_i};
      rdy_s2_r <= rdy_s1_r;
      eclk_r <= {eclk_r[1:0], efo_clk_i};
    end
  end

  assign mif.mon_en = ctrl_r[`CSC_CTRL_MON_EN];
  assign mif.efo_en = ctrl_r[`CSC_CTRL_EFO_EN];
  // edge taken between second and third stage, never from the first
  assign mif.efo_edge = eclk_r[2] ^ eclk_r[1];

  csc_clock_monitor #(
    .START_CYC(START_CYC)
  ) u_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mif(mif)
  );

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `CSC_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wb_dat_i[7:0];
      end
      if (fail_ev) begin
        // hardware wins over a concurrent software write
        ctrl_r[`CSC_CTRL_EFO_EN] <= 1'b0;
        if (cur_sel_r == csc_pkg::CSC_SRC_PLL && cfg_r[`CSC_CFG_PLL_SRC]) begin
          ctrl_r[`CSC_CTRL_PLL_EN] <= 1'b0;
        end
        // the fallback target must be running
        ctrl_r[`CSC_CTRL_IFO_EN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= `CSC_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= {3'h0, wb_dat_i[4:0]};
    end else if (fail_ev && cfg_r[1:0] != csc_pkg::CSC_SRC_IFO
                 && (cfg_r[1:0] == csc_pkg::CSC_SRC_EFO || cfg_r[`CSC_CFG_PLL_SRC])) begin
      cfg_r[1:0] <= csc_pkg::CSC_SRC_IFO;
    end
  end

  // ----------------------------------------------------------------
  // failure flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_flag_r <= 1'b0;
    end else if (fail_ev) begin
      fail_flag_r <= 1'b1;
    end else if (wr_fail && wb_dat_i[0]) begin
      fail_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_r <= 1'b0;
      nmi_r <= 1'b0;
    end else begin
      brk_r <= fail_ev;
      // non-maskable: no mask bit exists; held until software clears the flag
      nmi_r <= fail_ev || (fail_flag_r && !(wr_fail && wb_dat_i[0]));
    end
  end

  // ----------------------------------------------------------------
  // glitch-free source switch
  // ----------------------------------------------------------------
  // a failing source is dropped at once, other moves wait for readiness
  always_comb begin
    want_sel = cfg_r[1:0];
    if (want_sel == 2'b11) begin
      want_sel = csc_pkg::CSC_SRC_IFO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_sel_r <= csc_pkg::CSC_SRC_IFO;
      gap_r <= 4'h0;
      gate_r <= 1'b1;
    end else if (fail_ev && cur_sel_r != csc_pkg::CSC_SRC_IFO
                 && (cur_sel_r == csc_pkg::CSC_SRC_EFO || cfg_r[`CSC_CFG_PLL_SRC])) begin
      cur_sel_r <= csc_pkg::CSC_SRC_IFO;
      gap_r <= `CSC_SW_GAP;
      gate_r <= 1'b0;
    end else if (gap_r != 4'h0) begin
      gap_r <= gap_r - 4'h1;
      gate_r <= (gap_r == 4'h1);
    end else if (want_sel != cur_sel_r && src_ok(want_sel, ctrl_r)
                 && rdy_s2_r[want_sel]) begin
      cur_sel_r <= want_sel;
      gap_r <= `CSC_SW_GAP;
      gate_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // steering outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // same as the control register reset: internal fast and internal slow run
      ifo_en_o <= 1'b1;
      efo_en_o <= 1'b0;
      pll_en_o <= 1'b0;
      iso_en_o <= 1'b1;
      eso_en_o <= 1'b0;
      efo_bypass_o <= 1'b0;
      eso_bypass_o <= 1'b0;
      core_sel_o <= csc_pkg::CSC_SRC_IFO;
      core_gate_o <= 1'b0;
      pll_src_efo_o <= 1'b0;
      cal_sel_o <= csc_pkg::CSC_CAL_NONE;
      wdog_clk_en_o <= 1'b1;
      tim_break_o <= 1'b0;
      nmi_o <= 1'b0;
    end else begin
      ifo_en_o <= ctrl_r[`CSC_CTRL_IFO_EN];
      efo_en_o <= ctrl_r[`CSC_CTRL_EFO_EN];
      pll_en_o <= ctrl_r[`CSC_CTRL_PLL_EN];
      // the watchdog always needs the internal slow clock
      iso_en_o <= ctrl_r[`CSC_CTRL_ISO_EN] || 1'b1;
      eso_en_o <= ctrl_r[`CSC_CTRL_ESO_EN];
      efo_bypass_o <= ctrl_r[`CSC_CTRL_EFO_BYP];
      eso_bypass_o <= ctrl_r[`CSC_CTRL_ESO_BYP];
      core_sel_o <= cur_sel_r;
      core_gate_o <= gate_r;
      pll_src_efo_o <= cfg_r[`CSC_CFG_PLL_SRC];
      cal_sel_o <= cfg_r[`CSC_CFG_CAL_LO +: 2];
      wdog_clk_en_o <= 1'b1;
      tim_break_o <= brk_r;
      nmi_o <= nmi_r;
    end
  end

  // ----------------------------------------------------------------
  // wishbone answer: ack one cycle after the request, dropped next
  // ----------------------------------------------------------------
  always_comb begin
    dat_r = 32'h00000000;
    case (wb_adr_i)
      `CSC_ADDR_CTRL: dat_r = {24'h000000, ctrl_r};
      `CSC_ADDR_CFG: dat_r = {24'h000000, cfg_r};
      `CSC_ADDR_STAT: dat_r = {24'h000000, mif.armed, cur_sel_r, rdy_s2_r};
      `CSC_ADDR_FAIL: dat_r = {31'h00000000, fail_flag_r};
      default: dat_r = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_r <= req;
      wb_ack_o <= req;
      wb_dat_o <= req ? dat_r : 32'h00000000;
    end
  end
endmodule : csc_clock_source_security_ctrl

/* verif/csc_sec_assertions.sv */
`timescale 1ns/10ps
// ----------------------------------------
// failure and source-switch properties
// ----------------------------------------
module csc_sec_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  // watched outputs
  input wire logic efo_en_o,
  input wire logic pll_en_o,
  input wire logic [1:0] core_sel_o,
  input wire logic core_gate_o,
  input wire logic pll_src_efo_o,
  input wire logic wdog_clk_en_o,
  input wire logic tim_break_o,
  input wire logic nmi_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic fclr;
  assign fclr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h0c && wb_dat_i[0];

  chk_one_src: assert property (core_sel_o != 2'b11)
    else $error("core select out of range");
  chk_wdog_on: assert property (wdog_clk_en_o)
    else $error("watchdog clock off");
  chk_fail_needs_efo: assert property (tim_break_o |-> $past(efo_en_o) || $past(efo_en_o, 2))
    else $error("failure while external fast stopped");
  chk_efo_dropped: assert property (tim_break_o |-> ##[0:1] !efo_en_o)
    else $error("external fast kept on after failure");
  chk_break_pulse: assert property (tim_break_o |=> !tim_break_o)
    else $error("break longer than one cycle");
  chk_break_nmi: assert property ($rose(tim_break_o) |-> ##[0:1] nmi_o)
    else $error("no nmi with break");
  chk_to_internal: assert property ((tim_break_o && ($past(core_sel_o) == 2'b01 ||
    ($past(core_sel_o) == 2'b10 && pll_src_efo_o))) |-> ##[0:12] core_sel_o == 2'b00)
    else $error("core clock not moved to internal fast");
  chk_pll_dropped: assert property ((tim_break_o && $past(core_sel_o) == 2'b10 && pll_src_efo_o)
    |-> ##[0:2] !pll_en_o)
    else $error("pll kept on after failure");
  chk_nmi_holds: assert property ($fell(nmi_o) |-> $past(fclr) || $past(fclr, 2))
    else $error("nmi dropped without clear");
  chk_gate_gap: assert property ($fell(core_gate_o) |-> !core_gate_o[*3] ##[1:4] core_gate_o)
    else $error("switch gap wrong");
  chk_sel_gated: assert property ($changed(core_sel_o) |-> !core_gate_o || !$past(core_gate_o))
    else $error("source changed with gate open");
endmodule : csc_sec_checker

bind csc_clock_source_security_ctrl csc_sec_checker csc_sec_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .efo_en_o(efo_en_o),
  .pll_en_o(pll_en_o), .core_sel_o(core_sel_o), .core_gate_o(core_gate_o),
  .pll_src_efo_o(pll_src_efo_o), .wdog_clk_en_o(wdog_clk_en_o),
  .tim_break_o(tim_break_o), .nmi_o(nmi_o));

/* verif/csc_osc_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// oscillators outside the block
// ----------------------------------------
module csc_osc_model #(
  parameter int RDY_DLY = 8
) (
  // clock
  input wire logic clk_i,
  // enables: ifo, efo, pll, iso, eso
  input wire logic [4:0] en_i,
  input wire logic dead_i,
  // answers
  output logic [4:0] rdy_o,
  output logic efo_clk_o
);
  int cnt [5];
  logic [2:0] div_r = 3'h0;
  // ready only after a startup delay, dropped at once when disabled
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 5; i++) begin
      cnt[i] <= !en_i[i] ? 0 : (cnt[i] < RDY_DLY) ? cnt[i] + 1 : cnt[i];
    end
    div_r <= div_r + 3'h1;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      rdy_o[i] = (cnt[i] == RDY_DLY);
    end
  end
  // 25 MHz, half duty: legal in crystal and in bypass mode alike
  // stands low when stopped or when told to die
  assign efo_clk_o = en_i[1] && !dead_i && div_r[2];
endmodule : csc_osc_model

/* verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ifo_en_o, efo_en_o, efo_bypass_o, pll_en_o, iso_en_o, eso_en_o;
  logic eso_bypass_o, efo_clk, core_gate_o, pll_src_efo_o, wdog_clk_en_o, tim_break_o, nmi_o;
  logic [1:0] core_sel_o, cal_sel_o;
  logic [4:0] rdy;
  logic dead = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  int brk_cnt = 0;
  logic [7:0] scase [4] = '{8'h09, 8'h16, 8'h02, 8'h00};
  logic [7:0] fcase [4] = '{8'h01, 8'h06, 8'h02, 8'h00};

  csc_clock_source_security_ctrl #(.START_CYC(20)) csc_clock_source_security_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ifo_en_o(ifo_en_o), .efo_en_o(efo_en_o),
    .efo_bypass_o(efo_bypass_o), .pll_en_o(pll_en_o), .iso_en_o(iso_en_o),
    .eso_en_o(eso_en_o), .eso_bypass_o(eso_bypass_o), .ifo_rdy_i(rdy[0]),
    .efo_rdy_i(rdy[1]), .pll_rdy_i(rdy[2]), .iso_rdy_i(rdy[3]), .eso_rdy_i(rdy[4]),
    .efo_clk_i(efo_clk), .core_sel_o(core_sel_o), .core_gate_o(core_gate_o),
    .pll_src_efo_o(pll_src_efo_o), .cal_sel_o(cal_sel_o), .wdog_clk_en_o(wdog_clk_en_o),
    .tim_break_o(tim_break_o), .nmi_o(nmi_o));
  csc_osc_model csc_osc_model_inst (.clk_i(clk_i),
    .en_i({eso_en_o, iso_en_o, pll_en_o, efo_en_o, ifo_en_o}),
    .dead_i(dead), .rdy_o(rdy), .efo_clk_o(efo_clk));

  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (tim_break_o === 1'b1) brk_cnt <= brk_cnt + 1;

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic close_out();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic fail_now(input string m);
    err_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail_now
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) fail_now(m);
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) fail_now(m);
  endtask : chk_bit
  // request held until ack is seen at an edge, then idle one cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 40) begin
      fail_now("no bus answer");
      close_out();
    end
  endtask : wb
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 32'h0, q);
      n++;
    end while ((q & m) !== v && n < 200);
    if (n >= 200) begin
      fail_now("poll timeout");
      close_out();
    end
  endtask : poll
  task automatic setsrc(input logic [7:0] c);
    logic [31:0] q;
    wb(1'b1, 8'h0c - 8'h08, {24'h0, c}, q);
    poll(8'h08, 32'h60, {25'h0, c[1:0], 5'h0});
  endtask : setsrc
  function automatic logic [1:0] exp_src(input logic [7:0] c);
    return (c[1:0] == 2'b01 || (c[1:0] == 2'b10 && c[2])) ? 2'b00 : c[1:0];
  endfunction : exp_src

  initial begin
    repeat (100000) @(posedge clk_i);
    fail_now("run timeout");
    close_out();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic [7:0] c;
    int b;
    void'($urandom(55087));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0, q);
    chk_reg(q, 32'h09, "ctrl reset");
    wb(1'b0, 8'h10, 32'h0, q);
    chk_reg(q, 32'h0, "unmapped read");
    wb_sel_i <= 4'he;
    wb(1'b1, 8'h00, 32'h3f, q);
    wb_sel_i <= 4'hf;
    wb(1'b1, 8'h10, 32'h3f, q);
    wb(1'b0, 8'h00, 32'h0, q);
    chk_reg(q, 32'h09, "refused write landed");
    chk_bit(wdog_clk_en_o, 1'b1, "watchdog clock");
    repeat (8) begin
      c = (8'($urandom) & 8'hdf) | 8'h01;
      wb(1'b1, 8'h00, {24'h0, c}, q);
      wb(1'b0, 8'h00, 32'h0, q);
      chk_reg(q & 32'hf7, {24'h0, c & 8'hf7}, "ctrl readback");
      chk_reg({26'h0, eso_bypass_o, efo_bypass_o, eso_en_o, pll_en_o, efo_en_o, ifo_en_o},
              {26'h0, c[7:6], c[4], c[2:0]}, "enables");
      chk_bit(iso_en_o, 1'b1, "slow internal on");
    end
    wb(1'b1, 8'h00, 32'h17, q);
    poll(8'h08, 32'h1f, 32'h1f);
    for (int i = 0; i < 4; i++) begin
      c = scase[i];
      setsrc(c);
      chk_reg({27'h0, pll_src_efo_o, cal_sel_o, core_sel_o}, {27'h0, c[2], c[4:3], c[1:0]},
              "source select");
    end
    setsrc(8'h01);
    dead <= 1'b1;
    repeat (300) @(posedge clk_i);
    chk_bit(nmi_o, 1'b0, "monitor active while off");
    dead <= 1'b0;
    setsrc(8'h00);
    wb(1'b1, 8'h00, 32'h37, q);
    wb(1'b0, 8'h08, 32'h0, q);
    chk_bit(q[7], 1'b0, "armed too early");
    poll(8'h08, 32'h80, 32'h80);
    wb(1'b1, 8'h00, 32'h35, q);
    repeat (300) @(posedge clk_i);
    chk_bit(nmi_o, 1'b0, "failure on stopped oscillator");
    wb(1'b0, 8'h08, 32'h0, q);
    chk_bit(q[7], 1'b0, "monitor armed while stopped");
    for (int i = 0; i < 4; i++) begin
      c = fcase[i];
      wb(1'b1, 8'h00, 32'h37, q);
      poll(8'h08, 32'h1f, 32'h1f);
      setsrc(c);
      poll(8'h08, 32'h80, 32'h80);
      b = brk_cnt;
      dead <= 1'b1;
      poll(8'h0c, 32'h1, 32'h1);
      repeat (12) @(posedge clk_i);
      chk_reg(32'(brk_cnt - b), 32'h1, "break pulses");
      chk_bit(nmi_o, 1'b1, "nmi");
      chk_bit(efo_en_o, 1'b0, "external fast still on");
      chk_bit(pll_en_o, c != 8'h06, "pll enable");
      chk_reg({30'h0, core_sel_o}, {30'h0, exp_src(c)}, "source after failure");
      repeat (20) @(posedge clk_i);
      chk_bit(nmi_o, 1'b1, "nmi not held");
      dead <= 1'b0;
      wb(1'b1, 8'h0c, 32'h1, q);
      poll(8'h0c, 32'h1, 32'h0);
      chk_bit(nmi_o, 1'b0, "nmi not cleared");
    end
    close_out();
  end
endmodule : tb_top
